// [hw/uxf_params.svh]
`ifndef UXF_PARAMS_SVH
`define UXF_PARAMS_SVH
// Register byte addresses (APB, one word each)
`define UXF_ADDR_CTRL 12'h000
`define UXF_ADDR_STAT 12'h004
`define UXF_ADDR_MASK 12'h008
`define UXF_ADDR_ADDR 12'h00c
`define UXF_ADDR_RXD 12'h010
`define UXF_ADDR_TXD 12'h014
`define UXF_ADDR_LINE 12'h018
// Control field positions
`define UXF_B_IRDA 7
`define UXF_B_FLIP 5
`define UXF_B_AUTO 4
`define UXF_B_TXINH 2
`define UXF_B_RXINH 1
`define UXF_B_MULTI 0
`define UXF_CTRL_MASK 8'hb7
`define UXF_CTRL_RESET 8'h00
// Line config bits
`define UXF_B_SPECIAL 0
`define UXF_B_MDMRTS 1
`define UXF_B_HWFLOW 2
`define UXF_B_FLOWRTS 3
// Status bits
`define UXF_S_ADDR 0
`define UXF_S_TXDONE 1
`define UXF_S_RXAVAIL 2
// Bit timing: 16 ticks per bit
`define UXF_BAUD_DIV 16'd10
`define UXF_TICKS 4'd15
`define UXF_IRDA_SHORT 5'd3
`define UXF_IRDA_LONG 5'd4
`endif

// [hw/uxf_pkg.sv]
`default_nettype none
package uxf_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_STOP} uxf_tx_type;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_STOP} uxf_rx_type;
endpackage
`default_nettype wire

// [hw/uxf_tx.sv]
`include "uxf_params.svh"
`default_nettype none
// 9-bit serial transmitter with one-character (nine-bit) holding register
module uxf_tx (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // Load side
  input wire logic load,
  input wire logic [8:0] load_data,
  input wire logic inhibit,
  output logic busy,
  output logic full,
  // Line
  output logic txd,
  output logic shifting
);
  uxf_pkg::uxf_tx_type state;
  logic [8:0] hold;
  logic hold_v;
  logic [9:0] shreg;
  logic [3:0] bitn;
  logic [3:0] sub;
  // Start only on a tick so the start bit is a full bit time
  wire start_ok = (state == uxf_pkg::TX_IDLE) && hold_v && !inhibit &&
    tick;
  wire bit_end = tick && (sub == `UXF_TICKS);
  assign full = hold_v;
  assign busy = hold_v || (state != uxf_pkg::TX_IDLE);
  assign shifting = (state != uxf_pkg::TX_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 9'h000;
      hold_v <= 1'b0;
    end else if (load && !hold_v) begin
      hold <= load_data;
      hold_v <= 1'b1;
    end else if (start_ok) begin
      hold_v <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= uxf_pkg::TX_IDLE;
      shreg <= 10'h3ff;
      bitn <= 4'h0;
      sub <= 4'h0;
      txd <= 1'b1;
    end else begin
      if (tick)
        sub <= (sub == `UXF_TICKS) ? 4'h0 : sub + 4'h1;
      case (state)
        uxf_pkg::TX_IDLE: begin
          txd <= 1'b1;
          if (start_ok) begin
            shreg <= {hold, 1'b0};
            bitn <= 4'h0;
            sub <= 4'h0;
            state <= uxf_pkg::TX_SHIFT;
          end
        end
        uxf_pkg::TX_SHIFT: begin
          txd <= shreg[0];
          if (bit_end) begin
            shreg <= {1'b1, shreg[9:1]};
            bitn <= bitn + 4'h1;
            if (bitn == 4'd9)
              state <= uxf_pkg::TX_STOP;
          end
        end
        uxf_pkg::TX_STOP: begin
          txd <= 1'b1;
          if (bit_end)
            state <= uxf_pkg::TX_IDLE;
        end
        default: state <= uxf_pkg::TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/uxf_rx.sv]
`include "uxf_params.svh"
`default_nettype none
// 9-bit serial receiver, flushes partial frame when cut short
module uxf_rx (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // Control
  input wire logic inhibit,
  // Line, already synchronised
  input wire logic rxd,
  // Result
  output logic done,
  output logic [8:0] data,
  output logic active
);
  uxf_pkg::uxf_rx_type state;
  logic [8:0] shreg;
  logic [3:0] bitn;
  logic [3:0] sub;
  wire mid = tick && (sub == 4'd7);
  assign active = (state != uxf_pkg::RX_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= uxf_pkg::RX_IDLE;
      shreg <= 9'h000;
      bitn <= 4'h0;
      sub <= 4'h0;
      done <= 1'b0;
      data <= 9'h000;
    end else begin
      done <= 1'b0;
      if (tick)
        sub <= sub + 4'h1;
      case (state)
        uxf_pkg::RX_IDLE: begin
          if (!rxd && !inhibit) begin
            sub <= 4'h0;
            bitn <= 4'h0;
            state <= uxf_pkg::RX_SHIFT;
          end
        end
        uxf_pkg::RX_SHIFT: begin
          // Stop at once on inhibit, keep what was shifted
          if (inhibit) begin
            done <= (bitn != 4'h0);
            data <= shreg;
            state <= uxf_pkg::RX_IDLE;
          end else if (mid) begin
            if (bitn != 4'h0)
              shreg <= {rxd, shreg[8:1]};
            else if (rxd)
              state <= uxf_pkg::RX_IDLE;
            bitn <= bitn + 4'h1;
            if (bitn == 4'd9)
              state <= uxf_pkg::RX_STOP;
          end
        end
        uxf_pkg::RX_STOP: begin
          if (mid || inhibit) begin
            done <= 1'b1;
            data <= shreg;
            state <= uxf_pkg::RX_IDLE;
          end
        end
        default: state <= uxf_pkg::RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/uxf_core.sv]
`include "uxf_params.svh"
`default_nettype none
module uxf_core (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd_pin,
  output logic txd,
  output logic irda_tx,
  output logic rts_n,
  // Interrupt
  output logic irq
);
  logic [7:0] ctrl;
  logic [3:0] line_cfg;
  logic [7:0] addr_match;
  logic [2:0] status;
  logic [2:0] mask;
  logic [9:0] rx_word;
  logic rx_full;
  logic rx_en;
  logic rxd_m;
  logic rxd_s;
  logic [15:0] div;
  logic tick;
  logic [3:0] bit_sub;
  logic irda_q;
  logic dir_active;

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire sel_ctrl = paddr == `UXF_ADDR_CTRL;
  wire sel_stat = paddr == `UXF_ADDR_STAT;
  wire sel_mask = paddr == `UXF_ADDR_MASK;
  wire sel_addr = paddr == `UXF_ADDR_ADDR;
  wire sel_rxd = paddr == `UXF_ADDR_RXD;
  wire sel_txd = paddr == `UXF_ADDR_TXD;
  wire sel_line = paddr == `UXF_ADDR_LINE;
  wire mapped = sel_ctrl | sel_stat | sel_mask | sel_addr | sel_rxd |
    sel_txd | sel_line;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  wire multi = ctrl[`UXF_B_MULTI];
  wire special = line_cfg[`UXF_B_SPECIAL];
  wire auto_dir = ctrl[`UXF_B_AUTO];
  wire flip = ctrl[`UXF_B_FLIP];

  // Baud tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (div == `UXF_BAUD_DIV - 16'h0001);
      div <= (div == `UXF_BAUD_DIV - 16'h0001) ? 16'h0000 : div + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_m <= rxd_pin;
      rxd_s <= rxd_m;
    end
  end

  // Transmit path
  wire tx_load = wr && sel_txd;
  wire tx_busy;
  wire tx_full;
  wire tx_shift;
  uxf_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .load(tx_load),
    .load_data(pwdata[8:0]),
    .inhibit(ctrl[`UXF_B_TXINH]),
    .busy(tx_busy),
    .full(tx_full),
    .txd(txd),
    .shifting(tx_shift)
  );

  // Receive path
  wire rx_done;
  wire [8:0] rx_data;
  wire rx_active;
  // Multidrop keeps the shifter running to catch address characters
  uxf_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .inhibit(ctrl[`UXF_B_RXINH] && !multi),
    .rxd(rxd_s),
    .done(rx_done),
    .data(rx_data),
    .active(rx_active)
  );

  wire ninth = rx_data[8];
  wire is_match = ninth && (rx_data[7:0] == addr_match);
  // Acceptance of a finished character
  wire acc_plain = !multi;
  wire acc_norm = multi && !special && (rx_en || ninth);
  wire acc_auto = multi && special &&
    (ninth ? is_match : rx_en);
  wire accept = rx_done && (acc_plain || acc_norm || acc_auto);
  wire auto_off = rx_done && multi && special && ninth &&
    !is_match;
  wire auto_on = rx_done && multi && special && is_match;
  wire addr_evt = accept && multi && ninth;

  // Receive enable: software sets via inhibit clear; auto mode toggles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_en <= 1'b0;
    else if (auto_on)
      rx_en <= 1'b1;
    else if (auto_off)
      rx_en <= 1'b0;
    else if (wr && sel_ctrl)
      rx_en <= !pwdata[`UXF_B_RXINH];
  end

  // One-word receive holding, parity error slot carries ninth bit in multidrop mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word <= 10'h000;
      rx_full <= 1'b0;
    end else if (accept) begin
      rx_word <= {multi && ninth, rx_data};
      rx_full <= 1'b1;
    end else if (rd && sel_rxd) begin
      rx_full <= 1'b0;
    end
  end

  logic tx_busy_q;
  wire tx_done_p = tx_busy_q && !tx_busy;
  wire [2:0] events = {accept, tx_done_p, addr_evt};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_busy_q <= 1'b0;
    else
      tx_busy_q <= tx_busy;
  end

  // Set beats clear in the same cycle
  wire [2:0] w1c = (wr && sel_stat) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
      mask <= 3'h0;
    end else begin
      status <= (status & ~w1c) | events;
      if (wr && sel_mask)
        mask <= pwdata[2:0];
    end
  end
  assign irq = |(status & mask);

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `UXF_CTRL_RESET;
      line_cfg <= 4'h0;
      addr_match <= 8'h00;
    end else begin
      if (wr && sel_ctrl)
        ctrl <= pwdata[7:0] & `UXF_CTRL_MASK;
      if (wr && sel_line)
        line_cfg <= pwdata[3:0];
      if (wr && sel_addr)
        addr_match <= pwdata[7:0];
    end
  end

  // Direction: on from host write until last bit gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dir_active <= 1'b0;
    else if (tx_load)
      dir_active <= 1'b1;
    else if (!tx_busy)
      dir_active <= 1'b0;
  end
  wire legacy_rts_n = line_cfg[`UXF_B_HWFLOW] ?
    !line_cfg[`UXF_B_FLOWRTS] : !line_cfg[`UXF_B_MDMRTS];
  assign rts_n = auto_dir ? (dir_active ^~ flip) : legacy_rts_n;

  // IrDA pulse, counted in sixteenths of a bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bit_sub <= 4'h0;
    else if (!tx_shift)
      bit_sub <= 4'h0;
    else if (tick)
      bit_sub <= bit_sub + 4'h1;
  end
  wire [4:0] pw = ctrl[`UXF_B_IRDA] ? `UXF_IRDA_LONG : `UXF_IRDA_SHORT;
  logic irda_win;
  // Window delayed a cycle to line up with the registered txd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irda_win <= 1'b0;
      irda_q <= 1'b0;
    end else begin
      irda_win <= ({1'b0, bit_sub} < pw);
      irda_q <= tx_shift && !txd && irda_win;
    end
  end
  assign irda_tx = irda_q;

  // Read mux
  wire [31:0] rd_ctrl = {24'h0, ctrl};
  wire [31:0] rd_stat = {29'h0, status};
  wire [31:0] rd_mask = {29'h0, mask};
  wire [31:0] rd_addr = {24'h0, addr_match};
  wire [31:0] rd_rxd = {20'h0, rx_en, rx_full, rx_word};
  wire [31:0] rd_txd = {29'h0, rx_active, tx_full, tx_busy};
  wire [31:0] rd_line = {28'h0, line_cfg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= sel_ctrl ? rd_ctrl : sel_stat ? rd_stat :
        sel_mask ? rd_mask : sel_addr ? rd_addr : sel_rxd ? rd_rxd :
        sel_txd ? rd_txd : sel_line ? rd_line : 32'h0;
  end

  a_ctrl_reserved: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl[6] == 1'b0 && ctrl[3] == 1'b0)
    else $error("reserved control bits set");
  a_rts_assert: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_load && auto_dir |=> rts_n == flip)
    else $error("direction not asserted on write");
  a_rts_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_dir && !tx_busy && !tx_load && !(wr && sel_ctrl) |=>
    rts_n == !flip)
    else $error("direction not released after last bit");
  a_rts_legacy: assert property (
    @(posedge pclk) disable iff (!presetn)
    !auto_dir && !line_cfg[`UXF_B_HWFLOW] |->
    rts_n == !line_cfg[`UXF_B_MDMRTS])
    else $error("modem bit does not drive direction output");
  a_tx_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl[`UXF_B_TXINH] && !tx_shift |=> !tx_shift)
    else $error("transmit started while inhibited");
  a_rx_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl[`UXF_B_RXINH] && !multi && rx_active |=> !rx_active)
    else $error("receiver kept running while inhibited");
  a_drop_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_done && multi && !special && !rx_en && !ninth |=> !$rose(rx_full))
    else $error("data stored while disabled");
  a_addr_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    addr_evt |=> rx_word[9] && status[`UXF_S_ADDR])
    else $error("address not flagged");
  a_auto_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_done && multi && special && !rx_en && !is_match |=>
    $stable(rx_word))
    else $error("character stored while waiting for address");
  a_auto_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_on |=> rx_en && rx_full)
    else $error("matching address not taken");
  a_auto_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_off && !accept |=> !rx_en)
    else $error("mismatch did not disable");
  c_addr: cover property (@(posedge pclk) addr_evt);
  c_auto_on: cover property (@(posedge pclk) auto_on);
  c_auto_off: cover property (@(posedge pclk) auto_off);
  c_rx_flush: cover property (@(posedge pclk)
    rx_done && ctrl[`UXF_B_RXINH]);
  c_irda_long: cover property (@(posedge pclk)
    irda_tx && ctrl[`UXF_B_IRDA]);
endmodule
`default_nettype wire

// [verif/uxf_station.sv]
`default_nettype none
// Remote station on the multidrop line: sends frames, listens to ours
module uxf_station (
  // Clock
  input wire logic pclk,
  // Serial line
  output logic rxd,
  input wire logic txd,
  // Last character heard
  output logic [8:0] heard
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sixteen ticks of ten cycles each
  localparam int BIT_CYCLES = 160;
  initial begin
    rxd = 1'b1;
  end
  // Start, nine bits LSB first, stop; line left at idle high
  task automatic send(input logic [8:0] ch);
    logic [10:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= fr[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
  endtask
  // Mid-bit sampling tolerates a slightly late start edge
  always begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYCLES) @(posedge pclk);
      heard[i] = txd;
    end
    repeat (BIT_CYCLES) @(posedge pclk);
  end
endmodule
`default_nettype wire

// [verif/uxf_core_tb.sv]
`include "uxf_params.svh"
`default_nettype none
module uxf_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rxd_pin, txd, irda_tx, rts_n, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] heard;
  int n_mismatch = 0;
  int n_compared = 0;
  uxf_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd(txd), .irda_tx(irda_tx), .rts_n(rts_n),
    .irq(irq));
  uxf_station stn (.pclk(pclk), .rxd(rxd_pin), .txd(txd), .heard(heard));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail_out(input string what);
    n_mismatch++;
    $display("unexpected %s: expected done, seen timeout", what);
    give_verdict;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Entered right after a rising edge; one idle edge before returning
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) fail_out("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, exp,
                     input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd & m, exp);
  endtask
  // Poll until shifter and holding register are both empty
  task automatic wait_tx;
    int k;
    k = 0;
    do begin
      apb(1'b0, `UXF_ADDR_TXD, 32'h0);
      k++;
    end while (rd[1:0] !== 2'h0 && k < 1000);
    if (k >= 1000) fail_out("transmit idle");
  endtask
  // Skips a pulse already under way, then times the next whole one
  task automatic irda_width(input logic [31:0] exp);
    int k;
    int w;
    k = 0;
    w = 0;
    while (irda_tx !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    while (irda_tx !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) fail_out("irda pulse");
    while (irda_tx === 1'b1 && w < 100) begin
      @(posedge pclk);
      w++;
    end
    check("irda width", w, exp);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdm(`UXF_ADDR_CTRL, 32'hff, 32'h0, "control reset");
    wr(`UXF_ADDR_CTRL, 32'hff);
    rdm(`UXF_ADDR_CTRL, 32'hff, 32'hb7, "control rw");
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test registers done");
    wr(`UXF_ADDR_CTRL, 32'h0);
    wr(`UXF_ADDR_MASK, 32'h4);
    stn.send(9'h0a5);
    rdm(`UXF_ADDR_STAT, 32'h7, 32'h4, "status rx");
    check("irq raised", {31'h0, irq}, 32'h1);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'hca5, "plain char");
    wr(`UXF_ADDR_STAT, 32'h4);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test plain mode done");
    wr(`UXF_ADDR_CTRL, 32'h3);
    wr(`UXF_ADDR_MASK, 32'h1);
    stn.send(9'h033);
    rdm(`UXF_ADDR_RXD, 32'h400, 32'h0, "data dropped");
    stn.send(9'h155);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'h755, "address");
    check("address irq", {31'h0, irq}, 32'h1);
    wr(`UXF_ADDR_STAT, 32'h1);
    wr(`UXF_ADDR_CTRL, 32'h1);
    stn.send(9'h012);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'hc12, "data kept");
    stn.send(9'h1aa);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'hfaa, "next address");
    $display("test normal multidrop done");
    wr(`UXF_ADDR_LINE, 32'h1);
    wr(`UXF_ADDR_ADDR, 32'h3c);
    wr(`UXF_ADDR_CTRL, 32'h3);
    stn.send(9'h011);
    rdm(`UXF_ADDR_RXD, 32'h400, 32'h0, "auto data");
    stn.send(9'h177);
    rdm(`UXF_ADDR_RXD, 32'h400, 32'h0, "other address");
    stn.send(9'h13c);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'hf3c, "own address");
    stn.send(9'h044);
    rdm(`UXF_ADDR_RXD, 32'hfff, 32'hc44, "auto data kept");
    stn.send(9'h155);
    rdm(`UXF_ADDR_RXD, 32'hc00, 32'h0, "auto disable");
    wr(`UXF_ADDR_LINE, 32'h0);
    $display("test address detection done");
    wr(`UXF_ADDR_CTRL, 32'h0);
    fork
      stn.send(9'h0f0);
      begin
        repeat (800) @(posedge pclk);
        wr(`UXF_ADDR_CTRL, 32'h2);
      end
    join
    rdm(`UXF_ADDR_RXD, 32'hc00, 32'h400, "rx flush");
    $display("test receive inhibit done");
    wr(`UXF_ADDR_LINE, 32'h2);
    wr(`UXF_ADDR_CTRL, 32'h10);
    check("direction idle", {31'h0, rts_n}, 32'h1);
    wr(`UXF_ADDR_TXD, 32'h0c3);
    check("direction on", {31'h0, rts_n}, 32'h0);
    irda_width(32'd30);
    wait_tx;
    check("direction off", {31'h0, rts_n}, 32'h1);
    check("heard", {23'h0, heard}, 32'h0c3);
    wr(`UXF_ADDR_CTRL, 32'hb0);
    check("flip idle", {31'h0, rts_n}, 32'h0);
    wr(`UXF_ADDR_TXD, 32'h155);
    check("flip on", {31'h0, rts_n}, 32'h1);
    irda_width(32'd40);
    wait_tx;
    check("flip off", {31'h0, rts_n}, 32'h0);
    check("heard ninth", {23'h0, heard}, 32'h155);
    $display("test direction and irda done");
    wr(`UXF_ADDR_LINE, 32'h0);
    wr(`UXF_ADDR_CTRL, 32'h0);
    wr(`UXF_ADDR_TXD, 32'h0a5);
    repeat (300) @(posedge pclk);
    wr(`UXF_ADDR_CTRL, 32'h4);
    wait_tx;
    check("finished char", {23'h0, heard}, 32'h0a5);
    wr(`UXF_ADDR_TXD, 32'h05a);
    repeat (2000) @(posedge pclk);
    rdm(`UXF_ADDR_TXD, 32'h2, 32'h2, "held");
    check("nothing sent", {23'h0, heard}, 32'h0a5);
    wr(`UXF_ADDR_CTRL, 32'h0);
    wait_tx;
    check("sent after", {23'h0, heard}, 32'h05a);
    $display("test transmit inhibit done");
    give_verdict;
  end
endmodule
`default_nettype wire
